// File: dv/fieldbus_word_profile_16_32_tb_top.sv
// self-checking bench for the fieldbus word handler
`timescale 1ns/10ps
`default_nettype none
module fieldbus_word_profile_16_32_tb_top;
  logic                    clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic             [15:0] od_index, scale, v1, v2, sw;
  logic                    od_wr, od_rd, loc_fb, ack, err, stop_c, start_c, rev_c, frst, sec_loc;
  logic             [31:0] od_wdata, rdata, ctrl_w, lf, d;
  logic signed      [31:0] act1, act2, ref1, ref2;
  logic             [10:0] st;
  fwp_pkg::fwp_stop_mode_t cfg_mode, smode;
  int                      fail_count = 0;
  int                      total_checks = 0;
  logic             [33:0] exp_q[$];
  logic              [2:0] sb[5] = '{3'b001, 3'b000, 3'b010, 3'b100, 3'b111};
  fwp_pkg::fwp_stop_mode_t em[5] = '{fwp_pkg::FWP_STOP_NORMAL, fwp_pkg::FWP_STOP_QUICK, fwp_pkg::FWP_STOP_QUICK,
                                     fwp_pkg::FWP_STOP_FREEWHEEL, fwp_pkg::FWP_STOP_FREEWHEEL};
  logic             [16:0] bad[6] = '{17'h02001, 17'h02052, 17'h00000, 17'h12054, 17'h12056, 17'h1ffff};

  always #12.5 clk_i = ~clk_i;

  fwp_master_model m (.clk_i(clk_i), .od_index_o(od_index), .od_wr_o(od_wr), .od_rd_o(od_rd), .od_wdata_o(od_wdata));

  fwp_word_handler dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .od_index_i(od_index), .od_wr_i(od_wr), .od_rd_i(od_rd),
    .od_wdata_i(od_wdata), .od_rdata_o(rdata), .od_ack_o(ack), .od_err_o(err),
    .drive_ready_i(st[0]), .run_permit_flag_i(st[1]), .modulating_flag_i(st[2]), .zero_speed_i(st[3]),
    .target_reached_flag_i(st[4]), .limited_i(st[5]), .actual_over_threshold_flag_i(st[6]),
    .panel_local_i(st[7]), .fieldbus_local_i(st[8]), .ext_loc_sel_i(st[9]), .fault_i(st[10]),
    .scale_i(scale), .loc_from_fieldbus_i(loc_fb), .cfg_stop_mode_i(cfg_mode), .actual_one_i(act1),
    .actual_two_i(act2), .ctrl_word_o(ctrl_w), .stop_cmd_o(stop_c), .start_cmd_o(start_c),
    .reverse_cmd_o(rev_c), .stop_mode_o(smode), .fault_reset_o(frst),
    .secondary_external_location_o(sec_loc), .ref_one_o(ref1), .ref_two_o(ref2), .status_word_o(sw));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // status layout: unused positions stay zero
  function automatic logic [15:0] exp_sw(logic [10:0] s);
    return {s[10:7], 2'b00, s[6:4], 2'b00, s[3:2], 1'b0, s[1:0]};
  endfunction

  function automatic longint scl(longint a, logic [15:0] s);
    return (a * longint'({1'b0, s})) >>> fwp_pkg::SCALE_FRAC;
  endfunction

  function automatic logic [31:0] sat(longint p);
    if (p > 32767) return 32'h0000_7fff;
    if (p < -32768) return 32'hffff_8000;
    return 32'(p);
  endfunction

  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ack(logic [33:0] e);
    total_checks++;
    if (err !== e[32] || (e[33] && rdata !== e[31:0])) begin
      fail_count++;
      $display("[ERR] %0t access err %b data %h exp err %b data %h", $time, err, rdata, e[32], e[31:0]);
    end
  endtask

  // note the expected answer, then let the master issue the access
  task automatic acc(logic wr, logic [15:0] idx, logic [31:0] dt, logic e, logic cd, logic [31:0] ed);
    exp_q.push_back({cd, e, ed});
    m.access(wr, idx, dt);
  endtask

  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // every ack consumes the oldest note; sampled mid-cycle, away from the edge
  always @(negedge clk_i) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[ERR] %0t unexpected ack", $time);
      end
      else cmp_ack(exp_q.pop_front());
    end
  end

  // hang guard, far beyond the roughly 115 cycles the sequence needs
  initial begin
    #50000;
    fail_count++;
    summarize();
  end

  initial begin
    st = 11'h000;
    scale = 16'h0100;
    loc_fb = 1'b0;
    cfg_mode = fwp_pkg::FWP_STOP_QUICK;
    act1 = 32'sh0;
    act2 = 32'sh0;
    lf = 32'h8a38;
    repeat (2) @(posedge clk_i);
    #2;
    sys_rst_i = 1'b0;
    @(posedge clk_i);
    #2;
    cmp_val({12'h0, smode, sw}, 32'h0001_0000);
    // status bits follow the synchronised drive levels, first all ones
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      st = (i == 0) ? 11'h7ff : lf[10:0];
      repeat (4) @(posedge clk_i);
      #2;
      cmp_val({16'h0, sw}, {16'h0, exp_sw(st)});
      acc(1'b0, fwp_pkg::IDX_STATUS_WORD, 32'h0, 1'b0, 1'b1, {16'h0, exp_sw(st)});
    end
    // references: only bits 15:0 count, extreme value and scale first
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      scale = (i == 0) ? 16'hffff : lf[15:0];
      v1 = (i == 0) ? 16'h8000 : lf[31:16];
      lf = lfsr(lf);
      v2 = lf[15:0];
      acc(1'b1, fwp_pkg::IDX_REFERENCE_ONE, {lf[31:16], v1}, 1'b0, 1'b0, 32'h0);
      acc(1'b1, fwp_pkg::IDX_REFERENCE_TWO, {~lf[31:16], v2}, 1'b0, 1'b0, 32'h0);
      @(posedge clk_i);
      #2;
      cmp_val(ref1, 32'(scl($signed(v1), scale)));
      cmp_val(ref2, 32'(scl($signed(v2), scale)));
    end
    // actual values: saturation both ways, ordinary values, then a product far above the word
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      scale = (i == 2) ? 16'hffff : 16'h0180;
      act1 = (i == 0) ? 32'sh0010_0000 : (i == 1) ? {{16{lf[15]}}, lf[15:0]} : 32'sh7fff_ffff;
      act2 = (i == 0) ? -32'sd100000 : -32'sd300;
      acc(1'b0, fwp_pkg::IDX_ACTUAL_VALUE_ONE, 32'h0, 1'b0, 1'b1, sat(scl(act1, scale)));
      acc(1'b0, fwp_pkg::IDX_ACTUAL_VALUE_TWO, 32'h0, 1'b0, 1'b1, sat(scl(act2, scale)));
    end
    // control word: every stop-mode request plus the configured fallback
    for (int k = 0; k < 5; k++) begin
      lf = lfsr(lf);
      d = {lf[31:10], sb[k], lf[6:5], 1'b0, lf[3:0]};
      if (k == 0) d[2:0] = 3'b111;
      acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, d, 1'b0, 1'b0, 32'h0);
      cmp_val(ctrl_w, d);
      cmp_val({29'h0, rev_c, start_c, stop_c}, {29'h0, d[2:0]});
      cmp_val({28'h0, smode}, {28'h0, em[k]});
    end
    // fault reset only on a rising bit with a fault present
    st = 11'h400;
    repeat (4) @(posedge clk_i);
    acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, 32'h10, 1'b0, 1'b0, 32'h0);
    cmp_val({31'h0, frst}, 32'h1);
    acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, 32'h10, 1'b0, 1'b0, 32'h0);
    cmp_val({31'h0, frst}, 32'h0);
    acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, 32'h0, 1'b0, 1'b0, 32'h0);
    st = 11'h200;
    repeat (4) @(posedge clk_i);
    acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, 32'h10, 1'b0, 1'b0, 32'h0);
    cmp_val({31'h0, frst}, 32'h0);
    // location from the fieldbus overrides the external select input
    loc_fb = 1'b1;
    for (int j = 1; j >= 0; j--) begin
      acc(1'b1, fwp_pkg::IDX_CONTROL_WORD_WIDE, {26'h0, j[0], 5'h0}, 1'b0, 1'b0, 32'h0);
      repeat (2) @(posedge clk_i);
      #2;
      cmp_val({30'h0, sw[14], sec_loc}, {30'h0, j[0], j[0]});
    end
    // refused accesses leave the control word alone
    for (int i = 0; i < 6; i++) acc(bad[i][16], bad[i][15:0], 32'hffff_ffff, 1'b1, 1'b0, 32'h0);
    cmp_val(ctrl_w, 32'h0);
    repeat (3) @(posedge clk_i);
    cmp_val(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// File: dv/fwp_master_model.sv
// fieldbus master model issuing whole object accesses
`timescale 1ns/10ps
`default_nettype none
module fwp_master_model (
  input  wire logic        clk_i,
  output logic      [15:0] od_index_o,
  output logic             od_wr_o,
  output logic             od_rd_o,
  output logic      [31:0] od_wdata_o
);
  // idle bus at time zero
  initial begin
    od_index_o = 16'h0000;
    od_wr_o = 1'b0;
    od_rd_o = 1'b0;
    od_wdata_o = 32'h0000_0000;
  end

  // one request per call, launched just after an edge and held for the taking edge
  task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    #2;
    od_index_o = idx;
    od_wdata_o = d;
    od_wr_o = wr;
    od_rd_o = ~wr;
    @(posedge clk_i);
    #2;
    od_wr_o = 1'b0;
    od_rd_o = 1'b0;
    od_index_o = ~idx;
    od_wdata_o = ~d; // released data shows no stale copy
  endtask
endmodule
`default_nettype wire

// File: hw/fwp_pkg.sv
// constants and types for the fieldbus transparent-profile word handler
package fwp_pkg;

  // object dictionary indices
  localparam logic [15:0] IDX_CONTROL_WORD_WIDE = 16'h2001;
  localparam logic [15:0] IDX_REFERENCE_ONE     = 16'h2052;
  localparam logic [15:0] IDX_REFERENCE_TWO     = 16'h2053;
  localparam logic [15:0] IDX_STATUS_WORD       = 16'h2054;
  localparam logic [15:0] IDX_ACTUAL_VALUE_ONE  = 16'h2055;
  localparam logic [15:0] IDX_ACTUAL_VALUE_TWO  = 16'h2056;

  // status word bit positions
  localparam int ST_READY     = 0;
  localparam int ST_RUN_PERM  = 1;
  localparam int ST_MODULATE  = 3;
  localparam int ST_ZERO_SPD  = 4;
  localparam int ST_AT_TARGET = 7;
  localparam int ST_LIMITED   = 8;
  localparam int ST_OVER_THR  = 9;
  localparam int ST_PANEL_LOC = 12;
  localparam int ST_FBUS_LOC  = 13;
  localparam int ST_ALT_LOC   = 14;
  localparam int ST_FAULT     = 15;
  // bits that always read zero: 2, 5, 6, 10, 11
  localparam logic [15:0] ST_ZERO_MASK = 16'h0c64;

  // control word bit positions
  localparam int CW_STOP      = 0;
  localparam int CW_START     = 1;
  localparam int CW_REVERSE   = 2;
  localparam int CW_FLT_RESET = 4;
  localparam int CW_ALT_LOC   = 5;
  localparam int CW_NORM_DEC  = 7;
  localparam int CW_QUICK_DEC = 8;
  localparam int CW_FREEWHEEL = 9;

  // synchronised drive status inputs, index into the sync vector
  localparam int SI_READY     = 0;
  localparam int SI_RUN_PERM  = 1;
  localparam int SI_MODULATE  = 2;
  localparam int SI_ZERO_SPD  = 3;
  localparam int SI_AT_TARGET = 4;
  localparam int SI_LIMITED   = 5;
  localparam int SI_OVER_THR  = 6;
  localparam int SI_PANEL_LOC = 7;
  localparam int SI_FBUS_LOC  = 8;
  localparam int SI_LOC_SEL   = 9;
  localparam int SI_FAULT     = 10;
  localparam int SI_WIDTH     = 11;

  // widths and scaling
  localparam int NARROW_W   = 16;
  localparam int WIDE_W     = 32;
  localparam int SCALE_FRAC = 8;   // scale is unsigned q8.8
  localparam logic signed [32:0] ACT_MAX = 33'sh0_0000_7fff;
  localparam logic signed [32:0] ACT_MIN = 33'sh1_ffff_8000;

  // stop mode actually applied, one-hot
  typedef enum logic [3:0] {
    FWP_STOP_CONFIGURED = 4'b0001,
    FWP_STOP_NORMAL     = 4'b0010,
    FWP_STOP_QUICK      = 4'b0100,
    FWP_STOP_FREEWHEEL  = 4'b1000
  } fwp_stop_mode_t;

endpackage

// File: hw/fwp_sync2.sv
// two-flop synchroniser for drive status levels
`timescale 1ns/10ps
`default_nettype none
module fwp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: hw/fwp_word_handler.sv
// control/status word handler for the transparent 16/32 fieldbus profiles
// Functional notes
// RULE1 - status word readable at index 2054h
// RULE2 - bit 0 shows ready for start
// RULE3 - bit 1 shows external run enable
// RULE4 - bit 3 shows output modulating
// RULE5 - bit 4 shows zero speed
// RULE6 - bit 7 shows setpoint reached
// RULE7 - bit 8 shows operation limited
// RULE8 - bit 9 shows supervised value over limit
// RULE9 - bit 12 shows panel or tool local
// RULE10 - bit 13 shows fieldbus local control
// RULE11 - bit 14 shows second external location active
// RULE12 - bit 15 shows drive faulted
// RULE13 - bits 2,5,6,10,11 read zero
// RULE14 - two references at 2052h/2053h, one scale
// RULE15 - actual values at 2055h/2056h, same scale
// RULE16 - control word at 2001h passed unchanged
// RULE17 - bit 0 stops with requested mode
// RULE18 - bit 1 starts the drive
// RULE19 - bit 2 reverses rotation
// RULE20 - rising bit 4 clears active fault
// RULE21 - bit 5 picks location when fieldbus-selected
// RULE22 - bits 7-9 pick stop mode, else configured
`timescale 1ns/10ps
`default_nettype none
module fwp_word_handler (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // object dictionary access from the fieldbus stack
  input  wire logic [15:0]           od_index_i,
  input  wire logic                  od_wr_i,
  input  wire logic                  od_rd_i,
  input  wire logic [31:0]           od_wdata_i,
  output logic      [31:0]           od_rdata_o,
  output logic                       od_ack_o,
  output logic                       od_err_o,
  // drive status levels, asynchronous
  input  wire logic                  drive_ready_i,
  input  wire logic                  run_permit_flag_i,
  input  wire logic                  modulating_flag_i,
  input  wire logic                  zero_speed_i,
  input  wire logic                  target_reached_flag_i,
  input  wire logic                  limited_i,
  input  wire logic                  actual_over_threshold_flag_i,
  input  wire logic                  panel_local_i,
  input  wire logic                  fieldbus_local_i,
  input  wire logic                  ext_loc_sel_i,
  input  wire logic                  fault_i,
  // configuration and drive values, same clock
  input  wire logic [15:0]           scale_i,
  input  wire logic                  loc_from_fieldbus_i,
  input  wire fwp_pkg::fwp_stop_mode_t cfg_stop_mode_i,
  input  wire logic signed [31:0]    actual_one_i,
  input  wire logic signed [31:0]    actual_two_i,
  // towards drive control logic
  output logic      [31:0]           ctrl_word_o,
  output logic                       stop_cmd_o,
  output logic                       start_cmd_o,
  output logic                       reverse_cmd_o,
  output fwp_pkg::fwp_stop_mode_t    stop_mode_o,
  output logic                       fault_reset_o,
  output logic                       secondary_external_location_o,
  output logic signed [31:0]         ref_one_o,
  output logic signed [31:0]         ref_two_o,
  output logic      [15:0]           status_word_o
);

  logic [fwp_pkg::SI_WIDTH-1:0] st_sync;
  logic [15:0]                  status_d;
  logic [15:0]                  status_q;
  logic [15:0]                  ref_one_q;
  logic [15:0]                  ref_two_q;
  logic signed [15:0]           act_one_fb;
  logic signed [15:0]           act_two_fb;
  logic                         wr_ctrl;
  logic                         alt_loc_act;
  fwp_pkg::fwp_stop_mode_t      stop_mode_d;

  fwp_sync2 #(
    .WIDTH (fwp_pkg::SI_WIDTH)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({fault_i, ext_loc_sel_i, fieldbus_local_i, panel_local_i,
                 actual_over_threshold_flag_i, limited_i, target_reached_flag_i,
                 zero_speed_i, modulating_flag_i, run_permit_flag_i, drive_ready_i}),
    .sync_o    (st_sync)
  );

  // scale fieldbus word into drive units, q8.8 gain
  function automatic logic signed [31:0] to_drive(input logic [15:0] v, input logic [15:0] s);
    logic signed [32:0] p;
    p = 33'(signed'(v) * signed'({1'b0, s}));
    to_drive = 32'(p >>> fwp_pkg::SCALE_FRAC);
  endfunction

  // scale drive value to a 16-bit fieldbus word, saturating
  function automatic logic signed [15:0] to_fbus(input logic signed [31:0] v, input logic [15:0] s);
    logic signed [48:0] p;
    logic signed [40:0] q;
    p = 49'(v * signed'({1'b0, s}));
    // keep every quotient bit so saturation still sees very large products
    q = 41'(p >>> fwp_pkg::SCALE_FRAC);
    if (q > fwp_pkg::ACT_MAX) begin
      to_fbus = 16'sh7fff;
    end else if (q < fwp_pkg::ACT_MIN) begin
      to_fbus = 16'sh8000;
    end else begin
      to_fbus = 16'(q);
    end
  endfunction

  assign wr_ctrl    = od_wr_i && (od_index_i == fwp_pkg::IDX_CONTROL_WORD_WIDE);
  assign act_one_fb = to_fbus(actual_one_i, scale_i);
  assign act_two_fb = to_fbus(actual_two_i, scale_i);
  // location follows the control word only when so configured
  assign alt_loc_act = loc_from_fieldbus_i ? ctrl_word_o[fwp_pkg::CW_ALT_LOC] : st_sync[fwp_pkg::SI_LOC_SEL];

  // assemble the status word from synchronised levels; bit 14 from alt_loc_act, control word bit 5 when fieldbus-selected
  always_comb begin
    status_d = '0;                                                           // RULE13
    status_d[fwp_pkg::ST_READY]     = st_sync[fwp_pkg::SI_READY];            // RULE2
    status_d[fwp_pkg::ST_RUN_PERM]  = st_sync[fwp_pkg::SI_RUN_PERM];         // RULE3
    status_d[fwp_pkg::ST_MODULATE]  = st_sync[fwp_pkg::SI_MODULATE];         // RULE4
    status_d[fwp_pkg::ST_ZERO_SPD]  = st_sync[fwp_pkg::SI_ZERO_SPD];         // RULE5
    status_d[fwp_pkg::ST_AT_TARGET] = st_sync[fwp_pkg::SI_AT_TARGET];        // RULE6
    status_d[fwp_pkg::ST_LIMITED]   = st_sync[fwp_pkg::SI_LIMITED];          // RULE7
    status_d[fwp_pkg::ST_OVER_THR]  = st_sync[fwp_pkg::SI_OVER_THR];         // RULE8
    status_d[fwp_pkg::ST_PANEL_LOC] = st_sync[fwp_pkg::SI_PANEL_LOC];        // RULE9
    status_d[fwp_pkg::ST_FBUS_LOC]  = st_sync[fwp_pkg::SI_FBUS_LOC];         // RULE10
    status_d[fwp_pkg::ST_ALT_LOC]   = alt_loc_act;                           // RULE11
    status_d[fwp_pkg::ST_FAULT]     = st_sync[fwp_pkg::SI_FAULT];            // RULE12
  end

  // status word register, one more stage so every bit changes together
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign status_word_o = status_q;

  // stop mode: freewheel beats quick beats normal when several are set
  always_comb begin
    if (od_wdata_i[fwp_pkg::CW_FREEWHEEL]) begin                             // RULE22
      stop_mode_d = fwp_pkg::FWP_STOP_FREEWHEEL;
    end else if (od_wdata_i[fwp_pkg::CW_QUICK_DEC]) begin
      stop_mode_d = fwp_pkg::FWP_STOP_QUICK;
    end else if (od_wdata_i[fwp_pkg::CW_NORM_DEC]) begin
      stop_mode_d = fwp_pkg::FWP_STOP_NORMAL;
    end else begin
      stop_mode_d = cfg_stop_mode_i;
    end
  end

  // control word store and decoded command levels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_word_o   <= '0;
      stop_cmd_o    <= 1'b0;
      start_cmd_o   <= 1'b0;
      reverse_cmd_o <= 1'b0;
      stop_mode_o   <= fwp_pkg::FWP_STOP_CONFIGURED;
    end else if (wr_ctrl) begin
      ctrl_word_o   <= od_wdata_i;                                           // RULE16
      stop_cmd_o    <= od_wdata_i[fwp_pkg::CW_STOP];                         // RULE17
      start_cmd_o   <= od_wdata_i[fwp_pkg::CW_START];                        // RULE18
      reverse_cmd_o <= od_wdata_i[fwp_pkg::CW_REVERSE];                      // RULE19
      stop_mode_o   <= stop_mode_d;                                          // RULE17
    end
  end

  // fault reset fires on a written 0-to-1 edge, and only while faulted
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_reset_o <= 1'b0;
    end else begin
      fault_reset_o <= wr_ctrl && od_wdata_i[fwp_pkg::CW_FLT_RESET]          // RULE20
                       && !ctrl_word_o[fwp_pkg::CW_FLT_RESET] && st_sync[fwp_pkg::SI_FAULT];
    end
  end

  // location select output; follows the synchronised external select unless fieldbus-selected
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      secondary_external_location_o <= 1'b0;
    end else begin
      secondary_external_location_o <= alt_loc_act;                          // RULE21
    end
  end

  // references, kept raw and presented scaled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ref_one_q <= '0;
      ref_two_q <= '0;
    end else if (od_wr_i && od_index_i == fwp_pkg::IDX_REFERENCE_ONE) begin
      ref_one_q <= od_wdata_i[fwp_pkg::NARROW_W-1:0];                        // RULE14
    end else if (od_wr_i && od_index_i == fwp_pkg::IDX_REFERENCE_TWO) begin
      ref_two_q <= od_wdata_i[fwp_pkg::NARROW_W-1:0];                        // RULE14
    end
  end

  // scale registered so a change of scale_i shows one cycle later
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ref_one_o <= '0;
      ref_two_o <= '0;
    end else begin
      ref_one_o <= to_drive(ref_one_q, scale_i);                             // RULE14
      ref_two_o <= to_drive(ref_two_q, scale_i);
    end
  end

  // access answer: one cycle later; wrong direction or unknown index errors
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      od_ack_o   <= 1'b0;
      od_err_o   <= 1'b0;
      od_rdata_o <= '0;
    end else begin
      od_ack_o   <= od_wr_i || od_rd_i;
      od_err_o   <= 1'b0;
      od_rdata_o <= '0;
      if (od_rd_i) begin
        if (od_index_i == fwp_pkg::IDX_STATUS_WORD) begin
          od_rdata_o <= {16'h0000, status_q};                                // RULE1
        end else if (od_index_i == fwp_pkg::IDX_ACTUAL_VALUE_ONE) begin
          od_rdata_o <= {{16{act_one_fb[15]}}, act_one_fb};                  // RULE15
        end else if (od_index_i == fwp_pkg::IDX_ACTUAL_VALUE_TWO) begin
          od_rdata_o <= {{16{act_two_fb[15]}}, act_two_fb};                  // RULE15
        end else begin
          od_err_o <= 1'b1;
        end
      end else if (od_wr_i) begin
        if (od_index_i != fwp_pkg::IDX_CONTROL_WORD_WIDE && od_index_i != fwp_pkg::IDX_REFERENCE_ONE
            && od_index_i != fwp_pkg::IDX_REFERENCE_TWO) begin
          od_err_o <= 1'b1;
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence ctrl_edge_s;
    wr_ctrl && od_wdata_i[fwp_pkg::CW_FLT_RESET] && !ctrl_word_o[fwp_pkg::CW_FLT_RESET];
  endsequence

  status_read_a: assert property (od_rd_i && od_index_i == fwp_pkg::IDX_STATUS_WORD && !od_wr_i // RULE1
    |=> od_ack_o && !od_err_o && od_rdata_o == {16'h0000, $past(status_q)})
    else $error("status word read returned wrong data");
  status_bits_a: assert property (##1 status_q[fwp_pkg::ST_READY] == $past(st_sync[fwp_pkg::SI_READY]) // RULE2
    && status_q[fwp_pkg::ST_FAULT] == $past(st_sync[fwp_pkg::SI_FAULT]))
    else $error("status ready or fault bit does not follow input");
  status_run_a: assert property ($rose(run_permit_flag_i) ##1 run_permit_flag_i[*2] // RULE3
    |=> status_q[fwp_pkg::ST_RUN_PERM])
    else $error("run enable bit late");
  status_zero_a: assert property ((status_q & fwp_pkg::ST_ZERO_MASK) == 16'h0000) // RULE13
    else $error("reserved status bits not zero");
  ctrl_pass_a: assert property (wr_ctrl |=> ctrl_word_o == $past(od_wdata_i)) // RULE16
    else $error("control word not passed unchanged");
  fault_reset_a: assert property (ctrl_edge_s and st_sync[fwp_pkg::SI_FAULT] |=> fault_reset_o) // RULE20
    else $error("fault reset edge missed");
  fault_only_a: assert property (fault_reset_o |-> $past(st_sync[fwp_pkg::SI_FAULT]) // RULE20
    && !$past(ctrl_word_o[fwp_pkg::CW_FLT_RESET]) && ctrl_word_o[fwp_pkg::CW_FLT_RESET])
    else $error("fault reset without edge or fault");
  stop_cfg_a: assert property (wr_ctrl && !od_wdata_i[fwp_pkg::CW_NORM_DEC] // RULE22
    && !od_wdata_i[fwp_pkg::CW_QUICK_DEC] && !od_wdata_i[fwp_pkg::CW_FREEWHEEL]
    |=> stop_mode_o == $past(cfg_stop_mode_i))
    else $error("configured stop mode not applied");
  stop_coast_a: assert property (wr_ctrl && od_wdata_i[fwp_pkg::CW_FREEWHEEL] // RULE22
    |=> stop_mode_o == fwp_pkg::FWP_STOP_FREEWHEEL)
    else $error("freewheel stop not applied");
  loc_sel_a: assert property (!loc_from_fieldbus_i && $stable(st_sync[fwp_pkg::SI_LOC_SEL]) // RULE21
    |=> secondary_external_location_o == $past(st_sync[fwp_pkg::SI_LOC_SEL]))
    else $error("location changed without fieldbus selection");
  unmapped_a: assert property (od_rd_i && !od_wr_i && od_index_i == fwp_pkg::IDX_CONTROL_WORD_WIDE // RULE16
    |=> od_ack_o && od_err_o)
    else $error("read of write-only word not refused");
  ack_next_a: assert property ((od_wr_i || od_rd_i) |=> od_ack_o) // RULE1
    else $error("access not answered in the next cycle");
  ack_idle_a: assert property (!(od_wr_i || od_rd_i) |=> !od_ack_o && !od_err_o && od_rdata_o == '0) // RULE1
    else $error("answer without a request");
  cmd_levels_a: assert property (wr_ctrl |=> stop_cmd_o == $past(od_wdata_i[fwp_pkg::CW_STOP]) // RULE17 RULE18 RULE19
    && start_cmd_o == $past(od_wdata_i[fwp_pkg::CW_START])
    && reverse_cmd_o == $past(od_wdata_i[fwp_pkg::CW_REVERSE]))
    else $error("command levels differ from written bits");
  ctrl_hold_a: assert property (!wr_ctrl |=> $stable(ctrl_word_o) && $stable(stop_mode_o)) // RULE16
    else $error("control word changed without a write");
  stop_quick_a: assert property (wr_ctrl && !od_wdata_i[fwp_pkg::CW_FREEWHEEL] // RULE22
    && od_wdata_i[fwp_pkg::CW_QUICK_DEC]
    |=> stop_mode_o == fwp_pkg::FWP_STOP_QUICK)
    else $error("quick stop not applied");
  ref_store_a: assert property (od_wr_i && od_index_i == fwp_pkg::IDX_REFERENCE_TWO // RULE14
    |=> ref_two_q == $past(od_wdata_i[fwp_pkg::NARROW_W-1:0]))
    else $error("second reference not stored");

endmodule
`default_nettype wire
